// ### src/weighing_consts.vh
`ifndef WEIGHING_CONSTS_VH
`define WEIGHING_CONSTS_VH
// ****************************************
// register addresses (modbus holding)
// ****************************************
`define ADDR_STATUS 16'h9c41
`define ADDR_KEYS 16'h9c4b
`define ADDR_FW 16'h9c4c
`define ADDR_DATA_HI 16'h9e35
`define ADDR_DATA_LO 16'h9e36
`define ADDR_CMD 16'h9e37
`define ADDR_DIV 16'ha02c
`define ADDR_ZBAND 16'ha092
`define ADDR_SP1_MODE 16'ha0f1
`define ADDR_SP2_MODE 16'ha0f6
`define ADDR_AN_SRC 16'ha1bb
`define ADDR_AN_SPAN 16'ha1bc
`define ADDR_NV_LO 16'ha029
`define ADDR_NV_HI 16'ha1bc
// ****************************************
// status word fields
// ****************************************
`define ST_ZERO_CENTER 0
`define ST_STABLE 1
`define ST_ZERO_BAND 2
`define ST_TARE 3
`define ST_UNDER 4
`define ST_OVER 5
`define ST_OFF_RANGE 6
`define ST_LOCK 8
`define ST_MEM 9
`define ST_IN_LSB 10
`define ST_OUT_LSB 12
// ****************************************
// commands
// ****************************************
`define CMD_NONE 16'h0000
`define CMD_ZERO 16'h0001
`define CMD_TARE 16'h0002
`define CMD_PEAK_RST 16'h0003
`define CMD_CAL_ZERO 16'h0010
`define CMD_CAL_FS 16'h0011
`define CMD_SAVE 16'h0020
`define CMD_DIRECT 16'h7fff
// ****************************************
// encodings and reset values
// ****************************************
`define DIV_CODE_MAX 16'h000e
`define SRC_NET 2'h0
`define SRC_GROSS 2'h1
`define SRC_PEAK 2'h2
`define SPAN_MAX 16'h0003
`define SP_MODE_MASK 16'h001f
`define RST_DIV 16'h0000
`define RST_ZBAND 16'h0000
`define RST_SRC 16'h0000
`define RST_SPAN 16'h0000
`define PRINT_DELTA 32'd20
`endif

// ### src/weighing_register_map.v
`include "weighing_consts.vh"
module weighing_register_map (
    input wire sys_clk_i,
    input wire resetn_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    output reg [15:0] reg_rdata_o,
    output reg reg_err_o,
    input wire zero_center_i,
    input wire stable_i,
    input wire tare_entered_i,
    input wire underload_i,
    input wire overload_i,
    input wire cell_disconnected_i,
    input wire value_invalid_i,
    input wire keyboard_lock_i,
    input wire [1:0] inputs_i,
    input wire [1:0] outputs_i,
    input wire signed [31:0] gross_i,
    input wire signed [31:0] net_i,
    input wire set_key_i,
    input wire function_key_i,
    input wire zero_key_i,
    input wire program_key_i,
    input wire print_key_i,
    input wire [15:0] stability_check_setting_i,
    input wire key_blanking_function_i,
    input wire save_done_i,
    input wire [7:0] fw_version_i,
    input wire [7:0] fw_code_i,
    output reg zero_cmd_o,
    output reg tare_cmd_o,
    output reg peak_reset_o,
    output reg cal_zero_o,
    output reg cal_full_o,
    output reg [31:0] cal_weight_o,
    output reg save_start_o,
    output reg direct_access_o,
    output reg [15:0] division_select_o,
    output reg [15:0] zero_band_o,
    output reg [15:0] sp1_mode_o,
    output reg [15:0] sp2_mode_o,
    output reg [1:0] analog_source_o,
    output reg [1:0] analog_span_o,
    output reg [15:0] nv_division_o,
    output reg [15:0] nv_zero_band_o,
    output reg print_o
);
    // ****************************************
    // working and saved parameter copies
    // ****************************************
    reg [15:0] div_q;
    reg [15:0] zband_q;
    reg [15:0] sp1_q;
    reg [15:0] sp2_q;
    reg [15:0] src_q;
    reg [15:0] span_q;
    reg [15:0] nv_div_q;
    reg [15:0] nv_zband_q;
    reg [31:0] data_q;
    reg mem_flag_q;
    reg saving_q;
    reg printed_q;
    reg [15:0] rdata_d;
    reg err_d;
    reg signed [31:0] last_gross_q;
    wire nv_hit;
    wire save_cmd;
    wire [15:0] status_word;
    wire [15:0] key_word;
    wire off_range;
    wire zero_band;
    wire key_req;
    wire rem_req;
    wire stab_ok;
    wire moved;
    wire print_ok;
    wire signed [31:0] delta;
    wire [31:0] abs_delta;
    wire key_rise;
    wire rem_rise;

    assign nv_hit = reg_wr_i && (reg_addr_i >= `ADDR_NV_LO) && (reg_addr_i <= `ADDR_NV_HI);
    assign save_cmd = reg_wr_i && (reg_addr_i == `ADDR_CMD) && (reg_wdata_i == `CMD_SAVE);
    assign off_range = cell_disconnected_i | value_invalid_i;
    assign zero_band = (gross_i <= $signed({16'h0000, zband_q}));

    assign status_word = {2'b00, outputs_i, inputs_i, mem_flag_q, keyboard_lock_i, 1'b0,
                          off_range, overload_i, underload_i, tare_entered_i, zero_band,
                          stable_i, zero_center_i};
    assign key_word = {12'h000, program_key_i, zero_key_i, function_key_i, set_key_i};

    // ****************************************
    // register access
    // ****************************************
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= `RST_DIV;
            zband_q <= `RST_ZBAND;
            sp1_q <= 16'h0000;
            sp2_q <= 16'h0000;
            src_q <= `RST_SRC;
            span_q <= `RST_SPAN;
            data_q <= 32'h00000000;
        end else if (reg_wr_i) begin
            // out-of-range division, source and span codes are refused and mode words are masked so the encodings stay valid
            case (reg_addr_i)
                `ADDR_DIV: if (reg_wdata_i <= `DIV_CODE_MAX) div_q <= reg_wdata_i;
                `ADDR_ZBAND: zband_q <= reg_wdata_i;
                `ADDR_SP1_MODE: sp1_q <= reg_wdata_i & `SP_MODE_MASK;
                `ADDR_SP2_MODE: sp2_q <= reg_wdata_i & `SP_MODE_MASK;
                `ADDR_AN_SRC: if (reg_wdata_i <= {14'h0000, `SRC_PEAK}) src_q <= reg_wdata_i;
                `ADDR_AN_SPAN: if (reg_wdata_i <= `SPAN_MAX) span_q <= reg_wdata_i;
                `ADDR_DATA_HI: data_q[31:16] <= reg_wdata_i;
                `ADDR_DATA_LO: data_q[15:0] <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    always @* begin
        rdata_d = 16'h0000;
        err_d = 1'b0;
        case (reg_addr_i)
            `ADDR_STATUS: rdata_d = status_word;
            `ADDR_KEYS: rdata_d = key_word;
            `ADDR_FW: rdata_d = {fw_code_i, fw_version_i};
            `ADDR_DIV: rdata_d = div_q;
            `ADDR_ZBAND: rdata_d = zband_q;
            `ADDR_SP1_MODE: rdata_d = sp1_q;
            `ADDR_SP2_MODE: rdata_d = sp2_q;
            `ADDR_AN_SRC: rdata_d = src_q;
            `ADDR_AN_SPAN: rdata_d = span_q;
            // data and command words are write only
            default: err_d = 1'b1;
        endcase
    end

    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 16'h0000;
            reg_err_o <= 1'b0;
        end else begin
            reg_err_o <= 1'b0;
            if (reg_rd_i) begin
                // data holds until the next read
                reg_rdata_o <= rdata_d;
                reg_err_o <= err_d;
            end
        end
    end

    // ****************************************
    // command decode
    // ****************************************
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            zero_cmd_o <= 1'b0;
            tare_cmd_o <= 1'b0;
            peak_reset_o <= 1'b0;
            cal_zero_o <= 1'b0;
            cal_full_o <= 1'b0;
            cal_weight_o <= 32'h00000000;
            save_start_o <= 1'b0;
            direct_access_o <= 1'b0;
        end else begin
            zero_cmd_o <= 1'b0;
            tare_cmd_o <= 1'b0;
            peak_reset_o <= 1'b0;
            cal_zero_o <= 1'b0;
            cal_full_o <= 1'b0;
            save_start_o <= 1'b0;
            if (reg_wr_i && reg_addr_i == `ADDR_CMD) begin
                case (reg_wdata_i)
                    `CMD_NONE: begin
                    end
                    `CMD_ZERO: zero_cmd_o <= 1'b1;
                    `CMD_TARE: tare_cmd_o <= 1'b1;
                    `CMD_PEAK_RST: peak_reset_o <= 1'b1;
                    `CMD_CAL_ZERO: cal_zero_o <= 1'b1;
                    `CMD_CAL_FS: begin
                        // data register must already hold the sample weight
                        cal_full_o <= 1'b1;
                        cal_weight_o <= data_q;
                    end
                    `CMD_SAVE: save_start_o <= 1'b1;
                    `CMD_DIRECT: direct_access_o <= 1'b1;
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************
    // save and memory flag
    // ****************************************
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_flag_q <= 1'b0;
            saving_q <= 1'b0;
            nv_div_q <= `RST_DIV;
            nv_zband_q <= `RST_ZBAND;
        end else begin
            if (save_cmd) begin
                saving_q <= 1'b1;
                nv_div_q <= div_q;
                nv_zband_q <= zband_q;
            end else if (save_done_i) begin
                saving_q <= 1'b0;
            end
            // a new edit wins over the completion clear
            if (nv_hit) begin
                mem_flag_q <= 1'b1;
            end else if (saving_q && save_done_i) begin
                mem_flag_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // print request edges
    // ****************************************
    // pins are levels; only a fresh press may request a report
    rise_detect #(
        .IDLE(1'b0)
    ) u_key_edge (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .level_i(print_key_i),
        .rise_o(key_rise)
    );

    rise_detect #(
        .IDLE(1'b0)
    ) u_remote_edge (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .level_i(inputs_i[1]),
        .rise_o(rem_rise)
    );

    // ****************************************
    // print trigger
    // ****************************************
    assign key_req = key_rise && !keyboard_lock_i &&
                     !key_blanking_function_i;
    assign rem_req = rem_rise;
    assign stab_ok = (stability_check_setting_i == 16'h0000) || stable_i;
    assign delta = gross_i - last_gross_q;
    assign abs_delta = delta[31] ? (~delta + 32'h00000001) : delta;
    assign moved = !printed_q || (abs_delta >= `PRINT_DELTA);
    assign print_ok = (gross_i > 0) && (net_i > 0) && stab_ok && moved;

    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            printed_q <= 1'b0;
            last_gross_q <= 32'h00000000;
            print_o <= 1'b0;
        end else begin
            print_o <= 1'b0;
            if ((key_req || rem_req) && print_ok) begin
                print_o <= 1'b1;
                printed_q <= 1'b1;
                last_gross_q <= gross_i;
            end
        end
    end

    // ****************************************
    // parameter outputs
    // ****************************************
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            division_select_o <= `RST_DIV;
            zero_band_o <= `RST_ZBAND;
            sp1_mode_o <= 16'h0000;
            sp2_mode_o <= 16'h0000;
            analog_source_o <= `SRC_NET;
            analog_span_o <= 2'h0;
            nv_division_o <= `RST_DIV;
            nv_zero_band_o <= `RST_ZBAND;
        end else begin
            division_select_o <= div_q;
            zero_band_o <= zband_q;
            sp1_mode_o <= sp1_q;
            sp2_mode_o <= sp2_q;
            analog_source_o <= src_q[1:0];
            analog_span_o <= span_q[1:0];
            nv_division_o <= nv_div_q;
            nv_zero_band_o <= nv_zband_q;
        end
    end
endmodule

// ****************************************
// rising edge of a level pin
// ****************************************
module rise_detect #(
    parameter IDLE = 1'b0
) (
    input wire sys_clk_i,
    input wire resetn_i,
    input wire level_i,
    output wire rise_o
);
    reg prev_q;

    // starts at the idle level so reset release gives no false edge
    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_q <= IDLE;
        end else begin
            prev_q <= level_i;
        end
    end

    assign rise_o = level_i && !prev_q;
endmodule

// ### testbench/modbus_master_model.sv
`include "weighing_consts.vh"
// ****************************************
// modbus master stand-in
// ****************************************
module modbus_master_model (
    input logic clk_i,
    output logic wr_o,
    output logic rd_o,
    output logic [15:0] addr_o,
    output logic [15:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {wr_o, rd_o, addr_o, data_o} = '0;
    end
    // released address and data lines show the inverse so a stale value cannot pass; wr and rd drop to 0
    task automatic put(input bit w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_o <= w;
        rd_o <= !w;
        addr_o <= a;
        data_o <= d;
        @(posedge clk_i);
        {wr_o, rd_o} <= 2'h0;
        addr_o <= ~a;
        data_o <= ~d;
        #1;
    endtask
    task automatic cmd(input logic [15:0] c, input logic [31:0] v);
        put(1'b1, `ADDR_DATA_HI, v[31:16]);
        put(1'b1, `ADDR_DATA_LO, v[15:0]);
        put(1'b1, `ADDR_CMD, c);
    endtask
endmodule

// ### testbench/weighing_register_map_assertions.sv
`include "weighing_consts.vh"
// ****************************************
// port checks
// ****************************************
module weighing_register_map_assertions (
    input wire sys_clk_i,
    input wire resetn_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire [15:0] reg_rdata_o,
    input wire cell_disconnected_i,
    input wire value_invalid_i,
    input wire signed [31:0] gross_i,
    input wire signed [31:0] net_i,
    input wire set_key_i,
    input wire function_key_i,
    input wire zero_key_i,
    input wire program_key_i,
    input wire [7:0] fw_version_i,
    input wire [7:0] fw_code_i,
    input wire zero_cmd_o,
    input wire tare_cmd_o,
    input wire save_start_o,
    input wire direct_access_o,
    input wire print_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);
    wire rd_st = reg_rd_i && reg_addr_i == `ADDR_STATUS;
    wire rd_key = reg_rd_i && reg_addr_i == `ADDR_KEYS;
    wire rd_fw = reg_rd_i && reg_addr_i == `ADDR_FW;
    wire wr_cmd = reg_wr_i && reg_addr_i == `ADDR_CMD;
    status_spare_a:
        assert property (rd_st |=> reg_rdata_o[15:14] == 2'h0 && !reg_rdata_o[7])
        else $error("spare status bit set");
    off_range_a:
        assert property (rd_st |=> reg_rdata_o[6] ==
            ($past(cell_disconnected_i) | $past(value_invalid_i)))
        else $error("off range bit wrong");
    key_word_a:
        assert property (rd_key |=> reg_rdata_o == {12'h000, $past(program_key_i),
            $past(zero_key_i), $past(function_key_i), $past(set_key_i)})
        else $error("key word wrong");
    fw_word_a:
        assert property (rd_fw |=> reg_rdata_o == {$past(fw_code_i), $past(fw_version_i)})
        else $error("firmware word wrong");
    wire wr_zero = wr_cmd && reg_wdata_i == `CMD_ZERO;
    zero_pulse_a:
        assert property (wr_zero |=> zero_cmd_o ##1 (!zero_cmd_o || $past(wr_zero)))
        else $error("zero pulse wrong");
    tare_pulse_a:
        assert property (wr_cmd && reg_wdata_i == `CMD_TARE |=> tare_cmd_o && !zero_cmd_o)
        else $error("tare pulse wrong");
    save_pulse_a:
        assert property (wr_cmd && reg_wdata_i == `CMD_SAVE |=> save_start_o)
        else $error("save pulse missing");
    direct_sticky_a:
        assert property (direct_access_o || (wr_cmd && reg_wdata_i == `CMD_DIRECT)
            |=> direct_access_o)
        else $error("direct access lost");
    print_gate_a:
        assert property (print_o |-> $past(gross_i) > 0 && $past(net_i) > 0)
        else $error("print with bad weight");
endmodule
bind weighing_register_map weighing_register_map_assertions u_chk (
    .sys_clk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .cell_disconnected_i, .value_invalid_i, .gross_i, .net_i, .set_key_i, .function_key_i,
    .zero_key_i, .program_key_i, .fw_version_i, .fw_code_i, .zero_cmd_o, .tare_cmd_o,
    .save_start_o, .direct_access_o, .print_o
);

// ### testbench/weighing_register_map_tb.sv
`include "weighing_consts.vh"
module weighing_register_map_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i, reg_rd_i, reg_err_o, print_o;
    logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, sp1_mode_o, sp2_mode_o;
    logic zero_center_i, stable_i, tare_entered_i, underload_i, overload_i;
    logic cell_disconnected_i, value_invalid_i, keyboard_lock_i, direct_access_o;
    logic [1:0] inputs_i, outputs_i, analog_source_o, analog_span_o;
    logic signed [31:0] gross_i, net_i;
    logic set_key_i, function_key_i, zero_key_i, program_key_i, print_key_i;
    logic [15:0] stability_check_setting_i, division_select_o, zero_band_o;
    logic key_blanking_function_i, save_done_i, zero_cmd_o, tare_cmd_o, peak_reset_o;
    logic cal_zero_o, cal_full_o, save_start_o;
    logic [7:0] fw_version_i, fw_code_i;
    logic [31:0] cal_weight_o, w;
    logic [15:0] nv_division_o, nv_zero_band_o;
    wire [5:0] pulses = {zero_cmd_o, tare_cmd_o, peak_reset_o, cal_zero_o, cal_full_o,
        save_start_o};
    logic [15:0] cc[9] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0010, 16'h0011,
        16'h0020, 16'h7fff, 16'h0005};
    logic [5:0] ce[9] = '{6'h00, 6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h00, 6'h00};
    int bad_count = 0, checks = 0, lastg = 0;
    bit first = 1'b1, mem = 1'b0, r, e;
    weighing_register_map u_dut (.*);
    modbus_master_model u_mst (.clk_i(sys_clk_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
        .addr_o(reg_addr_i), .data_o(reg_wdata_i));
    always #10 sys_clk_i = ~sys_clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] x);
        u_mst.put(1'b0, a, 16'h0000);
        chk(reg_rdata_o, x);
    endtask
    // zero band is 10 counts here
    task automatic stat_loop;
        repeat (6) begin
            @(posedge sys_clk_i);
            {zero_center_i, stable_i, tare_entered_i, underload_i, overload_i,
                cell_disconnected_i, value_invalid_i, keyboard_lock_i, inputs_i,
                outputs_i} <= 12'($urandom);
            {set_key_i, function_key_i, zero_key_i, program_key_i, fw_version_i,
                fw_code_i} <= 20'($urandom);
            gross_i <= $urandom_range(40) - 20;
            #1;
            rd_chk(`ADDR_STATUS, {2'h0, outputs_i, inputs_i, mem, keyboard_lock_i, 1'b0,
                cell_disconnected_i | value_invalid_i, overload_i, underload_i,
                tare_entered_i, gross_i <= 10, stable_i, zero_center_i});
            rd_chk(`ADDR_KEYS, {program_key_i, zero_key_i, function_key_i, set_key_i});
            rd_chk(`ADDR_FW, {fw_code_i, fw_version_i});
        end
    endtask
    task automatic press(input bit remote, input bit x);
        @(posedge sys_clk_i);
        if (remote) inputs_i[1] <= 1'b1;
        else print_key_i <= 1'b1;
        @(posedge sys_clk_i);
        #1 chk(print_o, x);
        @(posedge sys_clk_i);
        inputs_i[1] <= 1'b0;
        print_key_i <= 1'b0;
    endtask
    initial begin
        #200us;
        bad_count++;
        stop_test();
    end
    initial begin
        {zero_center_i, stable_i, tare_entered_i, underload_i, overload_i, cell_disconnected_i,
            value_invalid_i, keyboard_lock_i, inputs_i, outputs_i, gross_i, net_i, set_key_i,
            function_key_i, zero_key_i, program_key_i, print_key_i, stability_check_setting_i,
            key_blanking_function_i, save_done_i, fw_version_i, fw_code_i} = '0;
        void'($urandom(89557));
        repeat (12) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        chk({reg_rdata_o, reg_err_o, print_o, direct_access_o, save_start_o}, 0);
        u_mst.put(1'b0, 16'h1234, 16'h0000);
        chk(reg_err_o, 1'b1);
        for (int c = 0; c < 16; c++) begin
            u_mst.put(1'b1, `ADDR_DIV, 16'(c));
            u_mst.put(1'b1, `ADDR_AN_SRC, 16'(c));
            u_mst.put(1'b1, `ADDR_AN_SPAN, 16'(c));
            rd_chk(`ADDR_DIV, c > 14 ? 14 : c);
            rd_chk(`ADDR_AN_SRC, c > 2 ? 2 : c);
            rd_chk(`ADDR_AN_SPAN, c > 3 ? 3 : c);
        end
        w = $urandom;
        u_mst.put(1'b1, `ADDR_SP1_MODE, w[15:0]);
        u_mst.put(1'b1, `ADDR_ZBAND, 16'h000a);
        u_mst.put(1'b1, `ADDR_SP2_MODE, w[31:16]);
        mem = 1'b1;
        rd_chk(`ADDR_SP1_MODE, w[4:0]);
        rd_chk(`ADDR_SP2_MODE, w[20:16]);
        chk({division_select_o, zero_band_o}, {16'h000e, 16'h000a});
        chk({analog_source_o, analog_span_o}, {2'h2, 2'h3});
        chk({sp1_mode_o, sp2_mode_o}, {11'h000, w[4:0], 11'h000, w[20:16]});
        chk(nv_division_o, 16'h0000);
        stat_loop();
        u_mst.put(1'b1, `ADDR_CMD, `CMD_SAVE);
        chk(save_start_o, 1'b1);
        @(posedge sys_clk_i);
        save_done_i <= 1'b1;
        @(posedge sys_clk_i);
        save_done_i <= 1'b0;
        mem = 1'b0;
        stat_loop();
        chk({nv_division_o, nv_zero_band_o}, {16'h000e, 16'h000a});
        for (int i = 0; i < 9; i++) begin
            w = $urandom;
            u_mst.cmd(cc[i], w);
            chk(pulses, ce[i]);
            if (i == 5) chk(cal_weight_o, w);
        end
        chk(direct_access_o, 1'b1);
        // random mix so lock, blanking and stability meet the weight step
        repeat (30) begin
            @(posedge sys_clk_i);
            inputs_i <= 2'h0;
            {stable_i, keyboard_lock_i, key_blanking_function_i} <= 3'($urandom);
            stability_check_setting_i <= 16'($urandom_range(1));
            gross_i <= $urandom_range(80) - 10;
            net_i <= $urandom_range(40) - 5;
            r = 1'($urandom);
            #1;
            e = gross_i > 0 && net_i > 0 && (stability_check_setting_i == 0 || stable_i)
                && (r || !(keyboard_lock_i || key_blanking_function_i))
                && (first || gross_i - lastg >= 20 || lastg - gross_i >= 20);
            press(r, e);
            if (e) begin
                lastg = gross_i;
                first = 1'b0;
            end
        end
        stop_test();
    end
endmodule
